// file: rtl/cec_pkg.sv
// Package of the CAN error tally and bit timing block.
// Assumes a single 40 MHz clock domain and an APB register slave.
package cec_pkg;

	// ==========================================
	// Register map
	localparam logic [11:0] ADDR_TALLY = 12'h000;
	localparam logic [11:0] ADDR_TIMING = 12'h004;
	localparam logic [11:0] ADDR_EVENTS = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;

	// ==========================================
	// Field layout and reset values
	localparam logic [2:0] SEG2_RESET = 3'h2;
	localparam logic [3:0] SEG1_RESET = 4'h3;
	localparam logic [6:0] REC_RESET = 7'h00;
	localparam logic [7:0] TEC_RESET = 8'h00;
	localparam int SEG2_LSB = 12;
	localparam int SEG1_LSB = 8;
	localparam int EVENT_WIDTH = 4;

	// ==========================================
	// Fault-confinement figures
	localparam logic [8:0] WARN_LEVEL = 9'h060;
	localparam logic [8:0] PASSIVE_LEVEL = 9'h080;
	localparam logic [8:0] TEC_LIMIT = 9'h100;
	localparam logic [3:0] STEP_ERROR = 4'h8;
	localparam logic [3:0] STEP_RX_MINOR = 4'h1;
	localparam logic [3:0] STEP_NONE = 4'h0;

	// Counter word as software sees it
	typedef struct packed {
		logic rxPassive;
		logic [6:0] rxCount;
		logic [7:0] txCount;
	} cec_tally_s;

	// Bus events that move the counters
	typedef struct packed {
		logic txError;
		logic txOk;
		logic rxError;
		logic rxErrorPrimary;
		logic rxOk;
	} cec_events_s;

	// Sticky event bits: halt, passive, warning, receive-passive
	typedef enum logic [1:0] {
		EV_HALT,
		EV_PASSIVE,
		EV_WARNING,
		EV_RXPASSIVE
	} cec_event_e;

endpackage

// file: rtl/cec_error_counter.sv
// Error tally word and bit-timing segments of a CAN controller, APB slave.
// Assumes the protocol engine gives one-cycle event pulses on the same clock.
// Function
// - Receive-passive flag is one at passive level, zero below.
// - Receive count shows as seven bits, fourteen down to eight.
// - Receive increment reaching 128 sets flag, count field unchanged.
// - Good reception while flagged clears flag, count minus one.
// - Transmit count shows as eight bits, seven down to zero.
// - Transmit increment reaching 256 sets halt, count field unchanged.
// - Counter word read-only, writes ignored, resets to zero.
// - Timing bit 15 reads zero; segment two resets 010, one 0011.
// - Passive status when flag set or transmit count 128 to 255.
// - Warning status when either count reaches 96.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module cec_error_counter (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protocol engine events
	input wire cec_pkg::cec_events_s busEvents,
	input wire logic haltClear,
	// Status out
	output cec_pkg::cec_tally_s tallyWord,
	output logic [2:0] secondTimeSegment,
	output logic [3:0] firstTimeSegment,
	output logic controllerHalt,
	output logic errorPassiveStatus,
	output logic errorWarningStatus,
	output logic irq
);

	// ==========================================
	// Counter arithmetic
	function automatic logic [8:0] addStep(input logic [7:0] base, input logic [3:0] step);
		addStep = {1'b0, base} + {5'h00, step};
	endfunction

	function automatic logic [7:0] subOne(input logic [7:0] base);
		subOne = (base == 8'h00) ? 8'h00 : base - 8'h01;
	endfunction

	function automatic logic reaches(input logic [7:0] count, input logic [8:0] level);
		reaches = {1'b0, count} >= level;
	endfunction

	cec_pkg::cec_tally_s tally_r;
	logic halt_r;
	logic passive_r;
	logic warning_r;
	logic [2:0] seg2_r;
	logic [3:0] seg1_r;
	logic [cec_pkg::EVENT_WIDTH-1:0] events_r;
	logic [cec_pkg::EVENT_WIDTH-1:0] mask_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic irq_r;

	// Receive step: primary errors weigh eight, others one
	wire logic [3:0] rxStep = busEvents.rxErrorPrimary ? cec_pkg::STEP_ERROR :
		busEvents.rxError ? cec_pkg::STEP_RX_MINOR : cec_pkg::STEP_NONE;
	wire logic [8:0] rxSum = addStep({1'b0, tally_r.rxCount}, rxStep);
	// Once passive the true count is past 127, so any further error is held too
	wire logic rxOverflow = (rxStep != cec_pkg::STEP_NONE)
		&& (tally_r.rxPassive || (rxSum >= cec_pkg::PASSIVE_LEVEL));
	wire logic [8:0] txSum = addStep(tally_r.txCount, cec_pkg::STEP_ERROR);
	wire logic txOverflow = busEvents.txError && (txSum >= cec_pkg::TEC_LIMIT);
	wire logic [7:0] rxDown = subOne({1'b0, tally_r.rxCount});

	// While halted the counters are frozen, as the engine is off the bus
	cec_pkg::cec_tally_s tally_nxt;
	always_comb begin
		tally_nxt = tally_r;
		if (!halt_r) begin
			if (busEvents.rxOk) begin
				tally_nxt.rxPassive = 1'b0;
				tally_nxt.rxCount = rxDown[6:0];
			end else if (rxOverflow) begin
				tally_nxt.rxPassive = 1'b1;
			end else if (rxStep != cec_pkg::STEP_NONE) begin
				tally_nxt.rxCount = rxSum[6:0];
			end
			if (busEvents.txError) begin
				if (!txOverflow) begin
					tally_nxt.txCount = txSum[7:0];
				end
			end else if (busEvents.txOk) begin
				tally_nxt.txCount = subOne(tally_r.txCount);
			end
		end
	end

	// ==========================================
	// Status derivation
	wire logic passive_nxt = tally_nxt.rxPassive || reaches(tally_nxt.txCount, cec_pkg::PASSIVE_LEVEL);
	wire logic warning_nxt = tally_nxt.rxPassive || reaches(tally_nxt.txCount, cec_pkg::WARN_LEVEL)
		|| reaches({1'b0, tally_nxt.rxCount}, cec_pkg::WARN_LEVEL);
	wire logic halt_nxt = (halt_r && !haltClear) || (!halt_r && txOverflow);

	always_ff @(posedge clock) begin
		if (reset) begin
			tally_r <= '0;
			halt_r <= 1'b0;
			passive_r <= 1'b0;
			warning_r <= 1'b0;
		end else begin
			tally_r <= tally_nxt;
			halt_r <= halt_nxt;
			passive_r <= passive_nxt;
			warning_r <= warning_nxt;
		end
	end

	// ==========================================
	// Sticky events and interrupt
	wire logic [cec_pkg::EVENT_WIDTH-1:0] rising;
	assign rising[cec_pkg::EV_HALT] = halt_nxt && !halt_r;
	assign rising[cec_pkg::EV_PASSIVE] = passive_nxt && !passive_r;
	assign rising[cec_pkg::EV_WARNING] = warning_nxt && !warning_r;
	assign rising[cec_pkg::EV_RXPASSIVE] = tally_nxt.rxPassive && !tally_r.rxPassive;

	// ==========================================
	// APB decode
	wire logic access = psel && penable;
	wire logic wrAccess = access && pwrite;
	wire logic hitTally = paddr == cec_pkg::ADDR_TALLY;
	wire logic hitTiming = paddr == cec_pkg::ADDR_TIMING;
	wire logic hitEvents = paddr == cec_pkg::ADDR_EVENTS;
	wire logic hitMask = paddr == cec_pkg::ADDR_MASK;
	wire logic hitStatus = paddr == cec_pkg::ADDR_STATUS;
	wire logic mapped = hitTally || hitTiming || hitEvents || hitMask || hitStatus;
	wire logic [cec_pkg::EVENT_WIDTH-1:0] clearBits = (wrAccess && hitEvents) ?
		pwdata[cec_pkg::EVENT_WIDTH-1:0] : '0;
	// Set wins over a same-cycle clear
	wire logic [cec_pkg::EVENT_WIDTH-1:0] events_nxt = (events_r & ~clearBits) | rising;

	// ==========================================
	// Read views of each register
	wire logic [31:0] tallyRead = {16'h0000, tally_r};
	wire logic [31:0] timingRead = {16'h0000, 1'b0, seg2_r, seg1_r, 8'h00};
	wire logic [31:0] eventsRead = {28'h000_0000, events_r};
	wire logic [31:0] maskRead = {28'h000_0000, mask_r};
	wire logic [31:0] statusRead = {29'h000_0000, halt_r, passive_r, warning_r};
	// Unmapped offsets read as zero and flag an error
	wire logic [31:0] readMux = hitTally ? tallyRead :
		hitTiming ? timingRead :
		hitEvents ? eventsRead :
		hitMask ? maskRead :
		hitStatus ? statusRead : 32'h0000_0000;

	always_ff @(posedge clock) begin
		if (reset) begin
			seg2_r <= cec_pkg::SEG2_RESET;
			seg1_r <= cec_pkg::SEG1_RESET;
			events_r <= '0;
			mask_r <= '0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			events_r <= events_nxt;
			irq_r <= |(events_nxt & mask_r);
			if (wrAccess && hitTiming) begin
				seg2_r <= pwdata[cec_pkg::SEG2_LSB +: 3];
				seg1_r <= pwdata[cec_pkg::SEG1_LSB +: 4];
			end
			if (wrAccess && hitMask) begin
				mask_r <= pwdata[cec_pkg::EVENT_WIDTH-1:0];
			end
			if (psel && !penable) begin
				prdata_r <= readMux;
				pslverr_r <= !mapped;
			end
		end
	end

	// Answer is registered in setup, so access phase completes at once
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign tallyWord = tally_r;
	assign secondTimeSegment = seg2_r;
	assign firstTimeSegment = seg1_r;
	assign controllerHalt = halt_r;
	assign errorPassiveStatus = passive_r;
	assign errorWarningStatus = warning_r;
	assign irq = irq_r;

	// ==========================================
	// Checks
	property p_rxflag;
		@(posedge clock) disable iff (reset)
		tally_r.rxPassive |-> ##0 passive_r;
	endproperty
	a_rxflag: assert property (p_rxflag) else $error("Passive low with flag set");

	property p_rxhold;
		@(posedge clock) disable iff (reset)
		(!halt_r && rxOverflow && !busEvents.rxOk) |=> (tally_r.rxPassive && $stable(tally_r.rxCount));
	endproperty
	a_rxhold: assert property (p_rxhold) else $error("Receive overflow moved count");

	property p_rxok;
		@(posedge clock) disable iff (reset)
		(!halt_r && busEvents.rxOk && tally_r.rxPassive && tally_r.rxCount != 7'h00) |=>
			(!tally_r.rxPassive && tally_r.rxCount == $past(tally_r.rxCount) - 7'h01);
	endproperty
	a_rxok: assert property (p_rxok) else $error("Good reception did not clear flag");

	property p_txhalt;
		@(posedge clock) disable iff (reset)
		(!halt_r && txOverflow) |=> (halt_r && $stable(tally_r.txCount));
	endproperty
	a_txhalt: assert property (p_txhalt) else $error("Transmit overflow missed halt");

	property p_ro;
		@(posedge clock) disable iff (reset)
		(wrAccess && hitTally && busEvents == '0) |=> $stable(tally_r);
	endproperty
	a_ro: assert property (p_ro) else $error("Counter word took a write");

	property p_timing;
		@(posedge clock) disable iff (reset)
		(wrAccess && hitTiming) |=> (seg2_r == $past(pwdata[14:12]) && seg1_r == $past(pwdata[11:8]));
	endproperty
	a_timing: assert property (p_timing) else $error("Timing write lost");

	property p_passive;
		@(posedge clock) disable iff (reset)
		##1 (passive_r == (tally_r.rxPassive || tally_r.txCount[7]));
	endproperty
	a_passive: assert property (p_passive) else $error("Passive status wrong");

	property p_warn;
		@(posedge clock) disable iff (reset)
		##1 (warning_r == (tally_r.rxPassive || tally_r.txCount >= 8'h60 || tally_r.rxCount >= 7'h60));
	endproperty
	a_warn: assert property (p_warn) else $error("Warning status wrong");

	property p_txstep;
		@(posedge clock) disable iff (reset)
		(!halt_r && busEvents.txError && !txOverflow) |=> tally_r.txCount == $past(tally_r.txCount) + 8'h08;
	endproperty
	a_txstep: assert property (p_txstep) else $error("Transmit step not eight");

	property p_rxset;
		@(posedge clock) disable iff (reset)
		$rose(tally_r.rxPassive) |-> $past(rxOverflow);
	endproperty
	a_rxset: assert property (p_rxset) else $error("Receive flag rose without overflow");

	property p_rxclear;
		@(posedge clock) disable iff (reset)
		(!halt_r && busEvents.rxOk) |=> !tally_r.rxPassive;
	endproperty
	a_rxclear: assert property (p_rxclear) else $error("Good reception left flag set");

	// Bus views are checked at the access edge against the word taken at setup
	property p_rxread;
		@(posedge clock) disable iff (reset)
		(access && hitTally && !pwrite) |-> (prdata_r[14:8] == $past(tally_r.rxCount));
	endproperty
	a_rxread: assert property (p_rxread) else $error("Receive count misplaced in read");

	property p_rxstep;
		@(posedge clock) disable iff (reset)
		(!halt_r && busEvents.rxErrorPrimary && !busEvents.rxOk && !rxOverflow) |=>
			(tally_r.rxCount == $past(tally_r.rxCount) + 7'h08);
	endproperty
	a_rxstep: assert property (p_rxstep) else $error("Receive step not eight");

	property p_txread;
		@(posedge clock) disable iff (reset)
		(access && hitTally && !pwrite) |-> (prdata_r[7:0] == $past(tally_r.txCount));
	endproperty
	a_txread: assert property (p_txread) else $error("Transmit count misplaced in read");

	property p_txok;
		@(posedge clock) disable iff (reset)
		(!halt_r && busEvents.txOk && !busEvents.txError && tally_r.txCount != 8'h00) |=>
			(tally_r.txCount == $past(tally_r.txCount) - 8'h01);
	endproperty
	a_txok: assert property (p_txok) else $error("Transmit success did not count down");

	property p_haltrise;
		@(posedge clock) disable iff (reset)
		$rose(halt_r) |-> $past(txOverflow);
	endproperty
	a_haltrise: assert property (p_haltrise) else $error("Halt without transmit overflow");

	property p_halthold;
		@(posedge clock) disable iff (reset)
		(halt_r && !haltClear) |=> halt_r;
	endproperty
	a_halthold: assert property (p_halthold) else $error("Halt dropped without clear");

	property p_frozen;
		@(posedge clock) disable iff (reset)
		halt_r |=> $stable(tally_r);
	endproperty
	a_frozen: assert property (p_frozen) else $error("Counters moved while halted");

	property p_passwarn;
		@(posedge clock) disable iff (reset)
		passive_r |-> warning_r;
	endproperty
	a_passwarn: assert property (p_passwarn) else $error("Passive without warning");

	property p_bit15;
		@(posedge clock) disable iff (reset)
		(access && hitTiming && !pwrite) |-> (prdata_r[15] == 1'b0);
	endproperty
	a_bit15: assert property (p_bit15) else $error("Reserved timing bit read as one");

	property p_segkeep;
		@(posedge clock) disable iff (reset)
		!(wrAccess && hitTiming) |=> ($stable(seg2_r) && $stable(seg1_r));
	endproperty
	a_segkeep: assert property (p_segkeep) else $error("Timing segments moved without write");

	property p_rstzero;
		@(posedge clock)
		$fell(reset) |-> (tally_r == '0);
	endproperty
	a_rstzero: assert property (p_rstzero) else $error("Counter word not zero after reset");

	property p_segreset;
		@(posedge clock)
		$fell(reset) |-> (seg2_r == cec_pkg::SEG2_RESET && seg1_r == cec_pkg::SEG1_RESET);
	endproperty
	a_segreset: assert property (p_segreset) else $error("Timing segments not at reset value");

	c_halt: cover property (@(posedge clock) disable iff (reset) !halt_r ##1 halt_r);
	c_rxpass: cover property (@(posedge clock) disable iff (reset) rising[cec_pkg::EV_RXPASSIVE]);
	c_irq: cover property (@(posedge clock) disable iff (reset) !irq_r ##1 irq_r);
	c_rxrecover: cover property (@(posedge clock) disable iff (reset) tally_r.rxPassive ##1 !tally_r.rxPassive);
	c_haltclear: cover property (@(posedge clock) disable iff (reset) halt_r ##1 !halt_r);

endmodule

// file: verification/cec_bus_node.sv
// Protocol engine stand-in: drives single-cycle bus event pulses.
// Assumes the block samples its events on the rising clock edge.
`timescale 1ns/10ps
module cec_bus_node (
	// Clock
	input wire logic clock,
	// Events towards the block
	output cec_pkg::cec_events_s busEvents
);
	initial busEvents = '0;
	// A quiet cycle between pulses, since no two frames end on adjacent edges
	task automatic send(input logic [4:0] kind, input int n);
		repeat (n) begin
			@(posedge clock);
			busEvents <= kind;
			@(posedge clock);
			busEvents <= '0;
		end
	endtask
endmodule

// file: verification/test_cec_error_counter.sv
// Self-checking bench of the error tally block over APB.
// Assumes a zero-wait APB slave and a partner that drives event pulses.
`timescale 1ns/10ps
module test_cec_error_counter;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic haltClear = 1'b0;
	cec_pkg::cec_events_s busEvents;
	cec_pkg::cec_tally_s tallyWord;
	logic [2:0] secondTimeSegment;
	logic [3:0] firstTimeSegment;
	logic controllerHalt;
	logic errorPassiveStatus;
	logic errorWarningStatus;
	logic irq;
	logic [31:0] rdData;
	logic rdErr;
	int nFail = 0;
	int samplesChecked = 0;

	always #12.5 clock = ~clock;

	cec_bus_node cec_bus_node_i (.clock(clock), .busEvents(busEvents));
	cec_error_counter cec_error_counter_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busEvents(busEvents), .haltClear(haltClear), .tallyWord(tallyWord),
		.secondTimeSegment(secondTimeSegment), .firstTimeSegment(firstTimeSegment),
		.controllerHalt(controllerHalt), .errorPassiveStatus(errorPassiveStatus),
		.errorWarningStatus(errorWarningStatus), .irq(irq));

	// ==========================================
	// Reporting
	task automatic finalReport();
		$display("checked %0d mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nFail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ==========================================
	// APB master
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			nFail++;
			finalReport();
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rdData);
	endtask

	task automatic flags(input logic [2:0] exp);
		repeat (2) @(posedge clock);
		chk("status", {29'h0, exp}, {29'h0, controllerHalt, errorPassiveStatus, errorWarningStatus});
	endtask

	// ==========================================
	// Scenarios
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_0000);
		rdChk("timing", cec_pkg::ADDR_TIMING, 32'h0000_2300);
		rdChk("unmapped", 12'h020, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, rdErr});
		apb(1'b1, cec_pkg::ADDR_TALLY, 32'h0000_FFFF);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_0000);
		apb(1'b1, cec_pkg::ADDR_TIMING, 32'h0000_F500);
		rdChk("timing", cec_pkg::ADDR_TIMING, 32'h0000_7500);
		chk("segments", 32'h0000_0075, {25'h0, secondTimeSegment, firstTimeSegment});
		cec_bus_node_i.send(5'h06, 12);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_6000);
		flags(3'h1);
		cec_bus_node_i.send(5'h06, 4);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_F800);
		flags(3'h3);
		cec_bus_node_i.send(5'h04, 1);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_F800);
		cec_bus_node_i.send(5'h01, 1);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_7700);
		cec_bus_node_i.send(5'h04, 1);
		cec_bus_node_i.send(5'h10, 16);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_7880);
		flags(3'h3);
		cec_bus_node_i.send(5'h10, 16);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_78F8);
		flags(3'h7);
		cec_bus_node_i.send(5'h06, 2);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_78F8);
		rdChk("status", cec_pkg::ADDR_STATUS, 32'h0000_0007);
		rdChk("events", cec_pkg::ADDR_EVENTS, 32'h0000_000F);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, cec_pkg::ADDR_MASK, 32'h0000_0001);
		repeat (2) @(posedge clock);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		apb(1'b1, cec_pkg::ADDR_EVENTS, 32'h0000_0001);
		repeat (2) @(posedge clock);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		rdChk("events", cec_pkg::ADDR_EVENTS, 32'h0000_000E);
		@(posedge clock);
		haltClear <= 1'b1;
		@(posedge clock);
		haltClear <= 1'b0;
		cec_bus_node_i.send(5'h08, 1);
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_78F7);
		chk("tallyWord", 32'h0000_78F7, {16'h0000, tallyWord});
		// Mid-run reset must restore the power-up counter word and timing segments
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rdChk("tally", cec_pkg::ADDR_TALLY, 32'h0000_0000);
		rdChk("timing", cec_pkg::ADDR_TIMING, 32'h0000_2300);
		chk("tallyWord", 32'h0000_0000, {16'h0000, tallyWord});
		finalReport();
	end
endmodule
